// [rtl/mif_irq_map.vh]
/*
 * register map, field positions, vectors and watchdog timing constants for
 * the interrupt flag and watchdog block.
 * assumes: included by bare name from rtl/ files; definitions only.
 */
`ifndef MIF_IRQ_MAP_VH
`define MIF_IRQ_MAP_VH

// ****************************************
// register byte addresses
// ****************************************
`define MIF_ADDR_W 5
`define MIF_ADDR_FLAG 5'h00
`define MIF_ADDR_ENABLE 5'h04
`define MIF_ADDR_POWER 5'h08
`define MIF_ADDR_PRESC 5'h0C
`define MIF_ADDR_WAKE 5'h10
`define MIF_ADDR_EXT 5'h14
`define MIF_ADDR_STATUS 5'h18

// ****************************************
// field positions
// ****************************************
`define MIF_BIT_T0 0
`define MIF_BIT_PB 1
`define MIF_BIT_EXT 2
`define MIF_BIT_T1 3
`define MIF_BIT_WDT 6
`define MIF_BIT_LVD 7
`define MIF_FLAG_MASK 8'hCF
`define MIF_BIT_RUN 7
`define MIF_BIT_ASSIGN 3
`define MIF_BIT_EDGE 1
`define MIF_BIT_EXTSEL 0
`define MIF_BIT_TOS 4
`define MIF_BIT_GIE 0

// ****************************************
// reset values
// ****************************************
`define MIF_RST_BYTE 8'h00
`define MIF_RST_WORD 32'h0000_0000
`define MIF_RST_TOS 1'b1
`define MIF_RST_RUN 1'b1

// ****************************************
// vectors and watchdog timing
// ****************************************
`define MIF_PC_W 10
`define MIF_VEC_TRAP 10'h001
`define MIF_VEC_HW 10'h008
`define MIF_WDT_T0_100US 35
`define MIF_WDT_T1_100US 150
`define MIF_WDT_T2_100US 600
`define MIF_WDT_T3_100US 2500
`define MIF_TIME_DIV 10000
`define MIF_PB_PINS 6

`endif

// [rtl/mif_irq_wdt.v]
/*
 * interrupt flag/enable logic, vectoring and watchdog for a small core.
 * registers sit behind an avalon-mm slave with waitrequest.
 * assumes: core strobes and timer wrap pulses are synchronous to i_clk;
 * pins, detector and watchdog oscillator are asynchronous.
 */
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mif_irq_map.vh"

module mif_irq_wdt #(
	parameter P_WDT_OSC_HZ = 32000,
	parameter P_WDT_CNT_W = 20,
	parameter P_WDT_TICKS_0 = `MIF_WDT_T0_100US * P_WDT_OSC_HZ / `MIF_TIME_DIV,
	parameter P_WDT_TICKS_1 = `MIF_WDT_T1_100US * P_WDT_OSC_HZ / `MIF_TIME_DIV,
	parameter P_WDT_TICKS_2 = `MIF_WDT_T2_100US * P_WDT_OSC_HZ / `MIF_TIME_DIV,
	parameter P_WDT_TICKS_3 = `MIF_WDT_T3_100US * P_WDT_OSC_HZ / `MIF_TIME_DIV
) (
	input wire i_clk,
	input wire i_reset_n,
	// avalon-mm slave
	input wire [`MIF_ADDR_W-1:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [3:0] i_avs_byteenable,
	output wire [31:0] o_avs_readdata,
	output wire o_avs_waitrequest,
	// core instruction strobes
	input wire i_instr_boundary,
	input wire i_trap_instr,
	input wire i_return_from_isr_instr,
	input wire i_global_enable_instr,
	input wire i_global_disable_instr,
	input wire i_clear_watchdog_instr,
	output wire o_vector_valid,
	output wire [`MIF_PC_W-1:0] o_vector_addr,
	output wire o_global_irq_enable,
	output wire o_watchdog_reset,
	// event sources
	input wire i_timer_zero_wrap,
	input wire i_timer_one_wrap,
	input wire [`MIF_PB_PINS-1:0] i_port_b_pins,
	input wire [`MIF_PB_PINS-1:0] i_port_b_is_input,
	input wire i_low_voltage_detector,
	input wire i_wdt_osc,
	// configuration words
	input wire i_cfg_wdt_enable,
	input wire i_cfg_wdt_irq_mode,
	input wire [1:0] i_cfg_wdt_period
);

// ****************************************
// state
// ****************************************
reg [7:0] flag_q;
reg [7:0] flag_d;
reg [7:0] enable_q;
reg watchdog_run_enable_q;
reg prescaler_assign_select_q;
reg [2:0] prescaler_ratio_field_q;
reg [`MIF_PB_PINS-1:0] wake_select_q;
reg ext_irq_pin_select_q;
reg ext_irq_edge_select_q;
reg timeout_status_flag_q;
reg global_irq_enable_q;
reg global_irq_enable_d;
reg vector_valid_q;
reg [`MIF_PC_W-1:0] vector_addr_q;
reg watchdog_reset_q;
reg wait_q;
reg [31:0] readdata_q;
reg [31:0] readdata_d;
reg [P_WDT_CNT_W-1:0] wdt_cnt_q;
reg [7:0] presc_cnt_q;
reg [P_WDT_CNT_W-1:0] wdt_limit;

// ****************************************
// synchronised inputs
// ****************************************
wire [`MIF_PB_PINS-1:0] pb_rise;
wire [`MIF_PB_PINS-1:0] pb_fall;
wire lvd_fall;
wire osc_rise;

// pins, detector and oscillator cross into i_clk once each
mif_sync_edge #(
	.W(`MIF_PB_PINS)
) u_sync_pb (
	.i_clk(i_clk),
	.i_reset_n(i_reset_n),
	.i_async(i_port_b_pins),
	.o_level(),
	.o_rise(pb_rise),
	.o_fall(pb_fall)
);

mif_sync_edge #(
	.W(1)
) u_sync_lvd (
	.i_clk(i_clk),
	.i_reset_n(i_reset_n),
	.i_async(i_low_voltage_detector),
	.o_level(),
	.o_rise(),
	.o_fall(lvd_fall)
);

mif_sync_edge #(
	.W(1)
) u_sync_osc (
	.i_clk(i_clk),
	.i_reset_n(i_reset_n),
	.i_async(i_wdt_osc),
	.o_level(),
	.o_rise(osc_rise),
	.o_fall()
);

// ****************************************
// bus decode
// ****************************************
// a write lands only on the edge where waitrequest is seen low
wire wr_strobe = i_avs_write & ~wait_q & i_avs_byteenable[0];
wire [7:0] wdata = i_avs_writedata[7:0];
wire wr_flag = wr_strobe & (i_avs_address == `MIF_ADDR_FLAG);
wire wr_enable = wr_strobe & (i_avs_address == `MIF_ADDR_ENABLE);
wire wr_power = wr_strobe & (i_avs_address == `MIF_ADDR_POWER);
wire wr_presc = wr_strobe & (i_avs_address == `MIF_ADDR_PRESC);
wire wr_wake = wr_strobe & (i_avs_address == `MIF_ADDR_WAKE);
wire wr_ext = wr_strobe & (i_avs_address == `MIF_ADDR_EXT);

// ****************************************
// event detection
// ****************************************
// pin 0 change is masked while pin 0 serves the external interrupt
wire [`MIF_PB_PINS-1:0] pb_watch = wake_select_q & i_port_b_is_input &
	~{{(`MIF_PB_PINS-1){1'b0}}, ext_irq_pin_select_q};
wire pb_change = |((pb_rise | pb_fall) & pb_watch);
wire ext_edge = ext_irq_pin_select_q &
	(ext_irq_edge_select_q ? pb_rise[0] : pb_fall[0]);

// ****************************************
// watchdog counting
// ****************************************
wire wdt_active = i_cfg_wdt_enable & watchdog_run_enable_q;
wire wdt_tick = osc_rise & wdt_active;
// with the prescaler assigned, interrupt mode shifts the ratio up one step
wire [3:0] presc_shift = prescaler_assign_select_q ?
	({1'b0, prescaler_ratio_field_q} + {3'b000, i_cfg_wdt_irq_mode}) : 4'h0;
wire [8:0] presc_ratio = 9'h001 << presc_shift;
wire [8:0] presc_last = presc_ratio - 9'h001;
wire presc_done = wdt_tick & ({1'b0, presc_cnt_q} == presc_last);
wire clear_wdt = i_clear_watchdog_instr;
// clear wins; >= stops a shortened period from running the count past its end
wire wdt_timeout = presc_done & ~clear_wdt &
	(wdt_cnt_q >= (wdt_limit - {{(P_WDT_CNT_W-1){1'b0}}, 1'b1}));

// base period picked by two configuration bits
always @* begin
	case (i_cfg_wdt_period)
	2'b00: begin
		wdt_limit = P_WDT_TICKS_0[P_WDT_CNT_W-1:0];
	end
	2'b01: begin
		wdt_limit = P_WDT_TICKS_1[P_WDT_CNT_W-1:0];
	end
	2'b10: begin
		wdt_limit = P_WDT_TICKS_2[P_WDT_CNT_W-1:0];
	end
	default: begin
		wdt_limit = P_WDT_TICKS_3[P_WDT_CNT_W-1:0];
	end
	endcase
end

// prescaler and counter; stopping holds the count
always @(posedge i_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		presc_cnt_q <= 8'h00;
		wdt_cnt_q <= {P_WDT_CNT_W{1'b0}};
	end else if (clear_wdt) begin
		if (prescaler_assign_select_q) begin
			presc_cnt_q <= 8'h00;
		end
		wdt_cnt_q <= {P_WDT_CNT_W{1'b0}};
	end else if (wdt_tick) begin
		if (presc_done) begin
			presc_cnt_q <= 8'h00;
			if (wdt_timeout) begin
				wdt_cnt_q <= {P_WDT_CNT_W{1'b0}};
			end else begin
				wdt_cnt_q <= wdt_cnt_q + {{(P_WDT_CNT_W-1){1'b0}}, 1'b1};
			end
		end else begin
			presc_cnt_q <= presc_cnt_q + 8'h01;
		end
	end
end

// timeout action and status flag
always @(posedge i_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		timeout_status_flag_q <= `MIF_RST_TOS;
		watchdog_reset_q <= 1'b0;
	end else begin
		watchdog_reset_q <= wdt_timeout & ~i_cfg_wdt_irq_mode;
		if (wdt_timeout) begin
			timeout_status_flag_q <= 1'b0;
		end else if (clear_wdt) begin
			timeout_status_flag_q <= 1'b1;
		end
	end
end

// ****************************************
// interrupt flags
// ****************************************
reg [7:0] flag_set;

always @* begin
	flag_set = `MIF_RST_BYTE;
	flag_set[`MIF_BIT_T0] = i_timer_zero_wrap;
	flag_set[`MIF_BIT_T1] = i_timer_one_wrap;
	flag_set[`MIF_BIT_WDT] = wdt_timeout & i_cfg_wdt_irq_mode;
	flag_set[`MIF_BIT_PB] = pb_change;
	flag_set[`MIF_BIT_EXT] = ext_edge;
	flag_set[`MIF_BIT_LVD] = lvd_fall;
	// writing 0 clears; a same-cycle event still sets
	flag_d = flag_q;
	if (wr_flag) begin
		flag_d = flag_q & wdata;
	end
	flag_d = (flag_d | flag_set) & `MIF_FLAG_MASK;
end

// ****************************************
// control registers
// ****************************************
always @(posedge i_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		flag_q <= `MIF_RST_BYTE;
		enable_q <= `MIF_RST_BYTE;
		watchdog_run_enable_q <= `MIF_RST_RUN;
		prescaler_assign_select_q <= 1'b0;
		prescaler_ratio_field_q <= 3'b000;
		wake_select_q <= {`MIF_PB_PINS{1'b0}};
		ext_irq_pin_select_q <= 1'b0;
		ext_irq_edge_select_q <= 1'b0;
	end else begin
		flag_q <= flag_d;
		if (wr_enable) begin
			enable_q <= wdata & `MIF_FLAG_MASK;
		end
		if (wr_power) begin
			watchdog_run_enable_q <= wdata[`MIF_BIT_RUN];
		end
		if (wr_presc) begin
			prescaler_assign_select_q <= wdata[`MIF_BIT_ASSIGN];
			prescaler_ratio_field_q <= wdata[2:0];
		end
		if (wr_wake) begin
			wake_select_q <= wdata[`MIF_PB_PINS-1:0];
		end
		if (wr_ext) begin
			ext_irq_pin_select_q <= wdata[`MIF_BIT_EXTSEL];
			ext_irq_edge_select_q <= wdata[`MIF_BIT_EDGE];
		end
	end
end

// ****************************************
// vectoring and global enable
// ****************************************
wire pending = |(flag_q & enable_q);
wire take_trap = i_instr_boundary & i_trap_instr;
// hardware requests only count at a boundary and lose to the trap
wire take_hw = i_instr_boundary & ~i_trap_instr & global_irq_enable_q & pending;

always @* begin
	global_irq_enable_d = global_irq_enable_q;
	if (take_trap | take_hw) begin
		global_irq_enable_d = 1'b0;
	end else if (i_return_from_isr_instr) begin
		global_irq_enable_d = 1'b1;
	end else if (i_global_enable_instr) begin
		global_irq_enable_d = 1'b1;
	end else if (i_global_disable_instr) begin
		global_irq_enable_d = 1'b0;
	end
end

// one vector pulse; flags are left for the routine to poll
always @(posedge i_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		global_irq_enable_q <= 1'b0;
		vector_valid_q <= 1'b0;
		vector_addr_q <= {`MIF_PC_W{1'b0}};
	end else begin
		global_irq_enable_q <= global_irq_enable_d;
		vector_valid_q <= take_trap | take_hw;
		if (take_trap) begin
			vector_addr_q <= `MIF_VEC_TRAP;
		end else if (take_hw) begin
			vector_addr_q <= `MIF_VEC_HW;
		end
	end
end

// ****************************************
// avalon read path
// ****************************************
always @* begin
	readdata_d = `MIF_RST_WORD;
	case (i_avs_address)
	`MIF_ADDR_FLAG: begin
		readdata_d[7:0] = flag_q & enable_q;
	end
	`MIF_ADDR_ENABLE: begin
		readdata_d[7:0] = enable_q;
	end
	`MIF_ADDR_POWER: begin
		readdata_d[`MIF_BIT_RUN] = watchdog_run_enable_q;
	end
	`MIF_ADDR_PRESC: begin
		readdata_d[`MIF_BIT_ASSIGN] = prescaler_assign_select_q;
		readdata_d[2:0] = prescaler_ratio_field_q;
	end
	`MIF_ADDR_WAKE: begin
		readdata_d[`MIF_PB_PINS-1:0] = wake_select_q;
	end
	`MIF_ADDR_EXT: begin
		readdata_d[`MIF_BIT_EXTSEL] = ext_irq_pin_select_q;
		readdata_d[`MIF_BIT_EDGE] = ext_irq_edge_select_q;
	end
	`MIF_ADDR_STATUS: begin
		readdata_d[`MIF_BIT_TOS] = timeout_status_flag_q;
		readdata_d[`MIF_BIT_GIE] = global_irq_enable_q;
	end
	default: begin
		readdata_d = `MIF_RST_WORD;
	end
	endcase
end

// fixed one-cycle wait: costs a cycle, keeps outputs registered
always @(posedge i_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		wait_q <= 1'b1;
		readdata_q <= `MIF_RST_WORD;
	end else if (wait_q) begin
		if (i_avs_read | i_avs_write) begin
			wait_q <= 1'b0;
		end
		if (i_avs_read) begin
			readdata_q <= readdata_d;
		end
	end else begin
		wait_q <= 1'b1;
	end
end

// ****************************************
// outputs
// ****************************************
assign o_avs_readdata = readdata_q;
assign o_avs_waitrequest = wait_q;
assign o_vector_valid = vector_valid_q;
assign o_vector_addr = vector_addr_q;
assign o_global_irq_enable = global_irq_enable_q;
assign o_watchdog_reset = watchdog_reset_q;

endmodule

`default_nettype wire

// [rtl/mif_sync_edge.v]
/*
 * two-flop synchroniser with edge detection for a group of slow inputs.
 * assumes: inputs may be asynchronous to i_clk; edges slower than the clock.
 */
`timescale 1ns/1ps
`default_nettype none

module mif_sync_edge #(
	parameter W = 1
) (
	input wire i_clk,
	input wire i_reset_n,
	input wire [W-1:0] i_async,
	output wire [W-1:0] o_level,
	output wire [W-1:0] o_rise,
	output wire [W-1:0] o_fall
);

reg [W-1:0] meta_q;
reg [W-1:0] sync_q;
reg [W-1:0] last_q;

// meta_q feeds sync_q only, never any logic
always @(posedge i_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		meta_q <= {W{1'b0}};
		sync_q <= {W{1'b0}};
		last_q <= {W{1'b0}};
	end else begin
		meta_q <= i_async;
		sync_q <= meta_q;
		last_q <= sync_q;
	end
end

// one pulse per edge, from settled stages only
assign o_level = sync_q;
assign o_rise = sync_q & ~last_q;
assign o_fall = ~sync_q & last_q;

endmodule

`default_nettype wire

// [tb/mif_core_model.sv]
/*
 core model: issues instruction strobes, records fetch redirects.
 assumes: bench calls step and reads the counters.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mif_irq_map.vh"
module mif_core_model (
	input wire i_clk,
	input wire i_vector_valid,
	input wire [`MIF_PC_W-1:0] i_vector_addr,
	output var logic [5:0] o_strobes
);
	// ***
	// instruction issue
	// ***
	int vec_cnt = 0;
	logic [`MIF_PC_W-1:0] last_vec = 10'h000;
	initial o_strobes = 6'h00;
	// one cycle {boundary, trap, return, enable, disable, clear}
	task automatic step(input logic [5:0] s);
		@(posedge i_clk);
		o_strobes <= s;
		@(posedge i_clk);
		o_strobes <= 6'h00;
		@(posedge i_clk);
		#1;
	endtask
	// redirect is a one-cycle pulse, so catch every one
	always @(posedge i_clk) begin
		if (i_vector_valid === 1'b1) begin
			vec_cnt <= vec_cnt + 1;
			last_vec <= i_vector_addr;
		end
	end
endmodule
`default_nettype wire

// [tb/mif_irq_wdt_bench.sv]
/*
 self-checking bench for mif_irq_wdt against an integer model.
 assumes: rtl/ on the include path; short watchdog counts.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mif_irq_map.vh"
module mif_irq_wdt_bench;
	// ***
	// stimulus, model state, instances
	// ***
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic avs_rd = 1'b0, avs_wr = 1'b0, t0 = 1'b0, t1 = 1'b0, lv = 1'b1, osc = 1'b0, cfg_en = 1'b0, cfg_irq = 1'b1;
	logic [4:0] adr = 5'h00;
	logic [31:0] wdat = 32'h0000_0000, rs = 32'h0000_09F4;
	logic [3:0] be = 4'h1;
	logic [5:0] pins = 6'h00, pdir = 6'h3F;
	logic [1:0] per = 2'h0;
	logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
	wire [31:0] rdat;
	wire [5:0] st;
	wire [9:0] vaddr;
	wire wreq, vv, genb, wrst;
	int failures = 0, samples_checked = 0, me = 0, mf = 0, mg = 0, mv = 0, ts = 1, n;
	always #4 i_clk = ~i_clk;
	// free-running watchdog oscillator, unrelated phase
	always #21 osc = ~osc;
	mif_irq_wdt #(.P_WDT_TICKS_0(2), .P_WDT_TICKS_1(3), .P_WDT_TICKS_2(4), .P_WDT_TICKS_3(5)) dut_u (
		.i_clk, .i_reset_n, .i_avs_address(adr), .i_avs_read(avs_rd), .i_avs_write(avs_wr),
		.i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
		.i_instr_boundary(st[5]), .i_trap_instr(st[4]), .i_return_from_isr_instr(st[3]),
		.i_global_enable_instr(st[2]), .i_global_disable_instr(st[1]), .i_clear_watchdog_instr(st[0]),
		.o_vector_valid(vv), .o_vector_addr(vaddr), .o_global_irq_enable(genb), .o_watchdog_reset(wrst),
		.i_timer_zero_wrap(t0), .i_timer_one_wrap(t1), .i_port_b_pins(pins), .i_port_b_is_input(pdir),
		.i_low_voltage_detector(lv), .i_wdt_osc(osc), .i_cfg_wdt_enable(cfg_en),
		.i_cfg_wdt_irq_mode(cfg_irq), .i_cfg_wdt_period(per));
	mif_core_model core_u (.i_clk, .i_vector_valid(vv), .i_vector_addr(vaddr), .o_strobes(st));
	// ***
	// helpers
	// ***
	function logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// request held until waitrequest is seen low at an edge
	task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int k;
		@(posedge i_clk);
		adr <= a;
		avs_wr <= w;
		avs_rd <= !w;
		wdat <= {rs[31:8], d}; // upper bytes are don't-care
		k = 0;
		do begin
			@(posedge i_clk);
			k++;
		end while (wreq !== 1'b0 && k < 50);
		if (k >= 50) begin
			failures++;
			finish_test;
		end
		avs_wr <= 1'b0;
		avs_rd <= 1'b0;
	endtask
	task rd(input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(rdat, {24'h00_0000, e});
	endtask
	task rf;
		rd(5'h00, 8'(mf & me));
	endtask
	task rst;
		rd(5'h18, 8'(ts * 16 + mg));
	endtask
	// writing 0 clears a flag, writing 1 leaves it
	task clr(input logic [7:0] d);
		bus(1'b1, 5'h00, d);
		mf = mf & d;
	endtask
	task tick(input int b);
		@(posedge i_clk);
		if (b == 0) t0 <= 1'b1;
		else t1 <= 1'b1;
		@(posedge i_clk);
		t0 <= 1'b0;
		t1 <= 1'b0;
		mf = mf | (b == 0 ? 1 : 8);
		@(posedge i_clk);
	endtask
	// pin events pass a synchroniser; 8 cycles covers it
	task ev(input logic [5:0] p, input logic l, input int b);
		pins <= p;
		lv <= l;
		repeat (8) @(posedge i_clk);
		mf = mf | b;
		rf();
	endtask
	task vchk(input logic [9:0] a);
		chk(core_u.vec_cnt, mv);
		chk({22'h00_0000, core_u.last_vec}, {22'h00_0000, a});
	endtask
	// gap between two watchdog resets, in oscillator periods
	task wgap(input logic [1:0] p, input int k);
		int ta, c;
		per <= p;
		c = 0;
		ta = 0;
		for (n = 0; n < 400 && c < 2; n++) begin
			@(posedge i_clk);
			if (wrst === 1'b1) c++;
			if (wrst === 1'b1 && c == 1) ta = $time;
		end
		if (c < 2) begin
			failures++;
			finish_test;
		end
		chk(32'(($time - ta + 8) / 42), 32'(k));
	endtask
	// ***
	// scenarios
	// ***
	initial begin
		repeat (3) @(posedge i_clk);
		i_reset_n <= 1'b1;
		for (n = 0; n < 8; n++) rd(5'(n * 4), rv[n]);
		bus(1'b1, 5'h04, 8'(xs())); // random enable pattern
		me = rs[7:0] & 8'hCF;
		rd(5'h04, 8'(me));
		be <= 4'h0;
		bus(1'b1, 5'h04, 8'h00);
		be <= 4'h1;
		rd(5'h04, 8'(me));
		$display("test registers done");
		bus(1'b1, 5'h04, 8'h00);
		me = 0;
		tick(0);
		rf();
		bus(1'b1, 5'h04, 8'hCF);
		me = 'hCF;
		rf();
		tick(1);
		rf();
		clr(8'hFE);
		rf();
		core_u.step(6'h04);
		mg = 1;
		rst();
		core_u.step(6'h20);
		mv++;
		mg = 0;
		vchk(10'h008);
		rf();
		core_u.step(6'h08);
		mg = 1;
		rst();
		core_u.step(6'h30);
		mv++;
		mg = 0;
		vchk(10'h001);
		rst();
		core_u.step(6'h30);
		mv++;
		vchk(10'h001);
		core_u.step(6'h04);
		core_u.step(6'h02);
		rst();
		core_u.step(6'h20);
		vchk(10'h001);
		$display("test vectoring done");
		clr(8'h00);
		bus(1'b1, 5'h10, 8'h3F);
		ev(6'h08, 1'b1, 'h02);
		ev(6'h08, 1'b0, 'h80);
		pdir <= 6'h2F;
		ev(6'h18, 1'b0, 'h00);
		pdir <= 6'h3F;
		clr(8'h00);
		bus(1'b1, 5'h14, 8'h03);
		ev(6'h19, 1'b0, 'h04);
		$display("test events done");
		clr(8'h00);
		cfg_en <= 1'b1;
		repeat (100) @(posedge i_clk);
		ts = 0;
		mf = mf | 'h40;
		rf();
		rst();
		bus(1'b1, 5'h08, 8'h00);
		bus(1'b1, 5'h0C, 8'h08);
		rd(5'h0C, 8'h08);
		core_u.step(6'h01);
		ts = 1;
		rst();
		repeat (100) @(posedge i_clk);
		rst();
		cfg_irq <= 1'b0;
		clr(8'h00);
		bus(1'b1, 5'h08, 8'h80);
		for (n = 0; n < 2000 && wrst !== 1'b1; n++) @(posedge i_clk);
		chk(32'(n < 2000), 32'h0000_0001);
		rf();
		for (int p = 0; p < 4; p++) wgap(2'(p), p + 2);
		bus(1'b1, 5'h0C, 8'h09);
		wgap(2'h3, 10);
		$display("test watchdog done");
		finish_test;
	end
endmodule
`default_nettype wire

// [tb/mif_irq_wdt_properties.sv]
/*
 port checker for mif_irq_wdt, bound to every instance.
 assumes: watchdog mode only moves from interrupt to reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mif_irq_map.vh"
module mif_irq_wdt_properties (
	input wire i_clk,
	input wire i_reset_n,
	input wire i_instr_boundary,
	input wire i_trap_instr,
	input wire i_return_from_isr_instr,
	input wire i_global_enable_instr,
	input wire i_global_disable_instr,
	input wire i_cfg_wdt_enable,
	input wire i_cfg_wdt_irq_mode,
	input wire o_vector_valid,
	input wire [`MIF_PC_W-1:0] o_vector_addr,
	input wire o_global_irq_enable,
	input wire o_watchdog_reset
);
	// ***
	// vectoring, global enable and watchdog reset
	// ***
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// short aliases keep the properties on one line
	wire bnd = i_instr_boundary;
	wire trp = i_trap_instr;
	wire gen = o_global_irq_enable;
	chk_trap_vector: assert property (bnd && trp |=> o_vector_valid && o_vector_addr == 10'h001)
		else $error("trap vector wrong");
	chk_trap_clears_enable: assert property (bnd && trp |=> !gen)
		else $error("trap left global enable set");
	chk_return_sets: assert property (i_return_from_isr_instr && !bnd |=> gen)
		else $error("return did not set global enable");
	chk_enable_instr: assert property (i_global_enable_instr && !bnd |=> gen)
		else $error("enable instruction ignored");
	chk_disable_instr: assert property (
		i_global_disable_instr && !i_global_enable_instr && !i_return_from_isr_instr && !bnd |=> !gen)
		else $error("disable instruction ignored");
	chk_hw_needs_enable: assert property (bnd && !trp && !gen |=> !o_vector_valid)
		else $error("vector taken while disabled");
	chk_hw_vector_addr: assert property (
		o_vector_valid && !$past(i_trap_instr) |-> o_vector_addr == 10'h008 && !gen)
		else $error("hardware vector wrong");
	chk_vector_boundary: assert property (o_vector_valid |-> $past(bnd))
		else $error("vector off a boundary");
	chk_wdt_reset_mode: assert property (
		o_watchdog_reset |-> !$past(i_cfg_wdt_irq_mode) && $past(i_cfg_wdt_enable))
		else $error("watchdog reset in wrong mode");
endmodule
bind mif_irq_wdt mif_irq_wdt_properties chk_u (.i_clk, .i_reset_n, .i_instr_boundary, .i_trap_instr,
	.i_return_from_isr_instr, .i_global_enable_instr, .i_global_disable_instr, .i_cfg_wdt_enable,
	.i_cfg_wdt_irq_mode, .o_vector_valid, .o_vector_addr, .o_global_irq_enable, .o_watchdog_reset);
`default_nettype wire
